// ==== hw/frb_pkg.sv ====
// Notes on behaviour
// RULE1 - buffered images may be sent only while continuous shot is off; the code checks it only when a request is taken in idle.
// RULE2 - with buffered path selected, one-shot or multi-shot requests trigger sending.
// RULE3 - multi-shot sends the requested number of buffered images, at least one.
// RULE4 - one-shot resends the last transmitted image from the retransmit buffer.
// RULE5 - while capture control is 1, each acquired image is stored in the ring.
// RULE6 - a full ring overwrites its oldest image with the new one.
// RULE7 - every transmitted image is copied into the retransmit buffer.
// RULE8 - with no previous image a retransmit still sends, content undefined.
// RULE9 - writing capture control as 1 empties the image ring.
// RULE10 - a format change empties the ring and recomputes the capacity field.
// RULE11 - bit 0 switches capture off (0) or on (1).
// RULE12 - bit 1 picks live (0) or buffered (1) path; ignored while streaming.
// RULE13 - bits 8 to 19 read the ring capacity, never zero.
// RULE14 - bits 20 to 31 read the buffered_count held.
// RULE15 - writes to read-only fields and reserved bits 2 to 7 do nothing.
package frb_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam int ADDR_W = 16;
    localparam logic [ADDR_W-1:0] CTRL_OFF = 16'h0634;
    localparam int BUF_ON_BIT = 0;
    localparam int SEL_BIT = 1;
    localparam logic RST_BUF_ON = 1'h0;
    localparam logic RST_SEL = 1'h0;
    localparam logic [11:0] RST_CAP = 12'h001;
    localparam logic [11:0] CNT_ZERO = 12'h000;

    // ------------------------------------------------------------
    // carriers and states
    // ------------------------------------------------------------
    typedef struct packed {
        logic [11:0] held;     // images in ring
        logic [11:0] capacity; // images the ring may hold
        logic [5:0] rsvd;
        logic sel;             // transfer path
        logic buf_on;          // capture control
    } frb_ctrl_s;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_MULTI = 2'b01,
        ST_ONE = 2'b11
    } frb_state_e;

endpackage

// ==== hw/frb_top.sv ====
`timescale 1ns/1ps

// ------------------------------------------------------------
// small fifo in front of the transmit port
// ------------------------------------------------------------
module frb_fifo #(
    parameter int WIDTH = 32,
    parameter int DEPTH = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    // pointer width and the count at which the fifo is full
    localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam logic [PW:0] FULL_CNT = (PW+1)'(DEPTH);

    // storage is not reset; a slot is read only once the count marks it valid
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wptr_q;
    logic [PW-1:0] rptr_q;
    logic [PW:0] cnt_q;
    logic push;
    logic pop;

    // pointer step that also wraps for depths that are not a power of two
    function automatic logic [PW-1:0] ptr_inc(input logic [PW-1:0] p);
        ptr_inc = (p == PW'(DEPTH - 1)) ? '0 : p + PW'(1);
    endfunction

    // honest flags from the occupancy count
    assign in_ready = (cnt_q != FULL_CNT);
    assign out_valid = (cnt_q != '0);
    assign out_data = mem[rptr_q];
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // storage
    always_ff @(posedge pclk) begin
        if (push) begin
            mem[wptr_q] <= in_data;
        end
    end

    // pointers and count
    // a push and a pop in one cycle leave the count unchanged
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wptr_q <= '0;
            rptr_q <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wptr_q <= ptr_inc(wptr_q);
            end
            if (pop) begin
                rptr_q <= ptr_inc(rptr_q);
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + (PW+1)'(1);
            end else if (pop && !push) begin
                cnt_q <= cnt_q - (PW+1)'(1);
            end
        end
    end
endmodule

// ------------------------------------------------------------
// frame buffer with retransmit, apb control register
// ------------------------------------------------------------
module frb_top #(
    parameter int DATA_W = 32,
    parameter int RING_DEPTH = 8,
    parameter int TX_DEPTH = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [frb_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic stream_tx_en,
    input wire logic continuous_shot,
    input wire logic one_shot_req,
    input wire logic multi_shot_req,
    input wire logic [11:0] multi_count,
    input wire logic format_change,
    input wire logic [11:0] format_capacity,
    input wire logic cap_valid,
    output logic cap_ready,
    input wire logic [DATA_W-1:0] cap_data,
    output logic tx_valid,
    input wire logic tx_ready,
    output logic [DATA_W-1:0] tx_data
);
    // ring index width and the largest capacity the storage can hold
    localparam int RW = (RING_DEPTH > 1) ? $clog2(RING_DEPTH) : 1;
    localparam logic [11:0] RING_MAX = 12'(RING_DEPTH);

    // sequencer state and datapath registers
    frb_pkg::frb_state_e state_q;
    logic buf_on_q;
    logic sel_q;
    logic [11:0] capacity_q;
    logic [11:0] held_q;
    logic [11:0] remain_q;
    logic [RW-1:0] wr_q;
    logic [RW-1:0] rd_q;
    logic [DATA_W-1:0] ring [RING_DEPTH];
    logic [DATA_W-1:0] last_q;
    logic [31:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic tx_valid_q;
    logic [DATA_W-1:0] tx_data_q;
    frb_pkg::frb_ctrl_s rd_view;
    logic hit;
    logic wr_fire;
    logic ring_init;
    logic live;
    logic ring_wr;
    logic ring_pop;
    // combinational handshake into the transmit fifo
    logic push_valid;
    logic [DATA_W-1:0] push_data;
    logic push_ready;
    logic push_fire;
    logic permit;
    logic fifo_valid;
    logic fifo_pop;
    logic [DATA_W-1:0] fifo_data;

    // ring pointer step, wrapping at the current capacity rather than the depth
    function automatic logic [RW-1:0] ring_inc(input logic [RW-1:0] p, input logic [11:0] cap);
        ring_inc = (12'(p) + 12'h001 >= cap) ? '0 : p + RW'(1);
    endfunction

    // ------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------
    // decode of the single register address
    assign hit = (paddr == frb_pkg::CTRL_OFF);
    assign wr_fire = psel && penable && pready_q && pwrite && hit;
    // read view of the control register; reserved bits always read zero
    assign rd_view = '{held: held_q, capacity: capacity_q, rsvd: 6'h00,
                       sel: sel_q, buf_on: buf_on_q}; // RULE13 RULE14

    // one wait state, answer registered in the access phase
    // the answer is latched on the first access edge and stands one cycle
    // an unmapped address answers with an error and zero data
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h00000000;
        end else begin
            pready_q <= psel && penable && !pready_q;
            if (psel && penable && !pready_q) begin
                pslverr_q <= !hit;
                prdata_q <= (hit && !pwrite) ? rd_view : 32'h00000000;
            end else begin
                pslverr_q <= 1'b0;
            end
        end
    end

    // control bits; only bits 0 and 1 are writable
    // writes land only on the completing edge of the access phase
    // the path bit is frozen while streaming so a live send is never cut
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            buf_on_q <= frb_pkg::RST_BUF_ON;
            sel_q <= frb_pkg::RST_SEL;
        end else if (wr_fire) begin // RULE15
            buf_on_q <= pwdata[frb_pkg::BUF_ON_BIT]; // RULE11
            if (!stream_tx_en) begin // RULE12
                sel_q <= pwdata[frb_pkg::SEL_BIT];
            end
        end
    end

    // capacity follows the format, clamped to the ring and kept above zero
    // a zero capacity would leave the ring unusable, so it reads as one
    // values above the ring depth are clamped to the storage present
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capacity_q <= frb_pkg::RST_CAP;
        end else if (format_change) begin // RULE10
            if (format_capacity == 12'h000) begin // RULE13
                capacity_q <= 12'h001;
            end else if (format_capacity > RING_MAX) begin
                capacity_q <= RING_MAX;
            end else begin
                capacity_q <= format_capacity;
            end
        end
    end

    // ------------------------------------------------------------
    // image ring
    // ------------------------------------------------------------
    // ring control: init beats a capture in the same cycle; that capture is
    // still sent on the live path, only its ring copy is dropped
    // captures are always accepted unless the live path is backed up
    assign ring_init = (wr_fire && pwdata[frb_pkg::BUF_ON_BIT]) || format_change; // RULE9 RULE10
    assign live = stream_tx_en && !sel_q && (state_q == frb_pkg::ST_IDLE);
    assign cap_ready = live ? push_ready : 1'b1;
    assign ring_wr = buf_on_q && cap_valid && cap_ready && !ring_init; // RULE5

    // ring storage
    // not reset; the held count says which slots are valid
    always_ff @(posedge pclk) begin
        if (ring_wr) begin
            ring[wr_q] <= cap_data;
        end
    end

    // ring pointers and occupancy
    // a full ring moves the read pointer along with the write pointer, so
    // the oldest image is lost and the held count stays at capacity
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_q <= '0;
            rd_q <= '0;
            held_q <= frb_pkg::CNT_ZERO;
        end else if (ring_init) begin
            wr_q <= '0;
            rd_q <= '0;
            held_q <= frb_pkg::CNT_ZERO;
        end else if (ring_wr) begin
            wr_q <= ring_inc(wr_q, capacity_q);
            if (held_q >= capacity_q) begin // RULE6
                rd_q <= ring_inc(rd_q, capacity_q);
            end else begin
                held_q <= held_q + 12'h001;
            end
        end else if (ring_pop) begin
            rd_q <= ring_inc(rd_q, capacity_q);
            held_q <= held_q - 12'h001;
        end
    end

    // ------------------------------------------------------------
    // transmit engine
    // ------------------------------------------------------------
    // buffered sends need continuous shot off and the buffered path chosen
    // pops wait for a free cycle: a capture in flight has priority
    assign permit = !continuous_shot && sel_q; // RULE1 RULE2
    assign ring_pop = (state_q == frb_pkg::ST_MULTI) && !cap_valid && !ring_init &&
                      (held_q != 12'h000) && push_ready;

    // source select for the transmit fifo
    // one-shot repeats the retransmit copy, multi-shot drains the ring
    always_comb begin
        push_valid = 1'b0;
        push_data = cap_data;
        case (state_q)
            frb_pkg::ST_IDLE: begin
                push_valid = live && cap_valid;
            end
            frb_pkg::ST_ONE: begin
                push_valid = 1'b1;
                push_data = last_q; // RULE4 RULE8
            end
            frb_pkg::ST_MULTI: begin
                push_valid = ring_pop;
                push_data = ring[rd_q]; // RULE3
            end
            default: begin
                push_valid = 1'b0;
            end
        endcase
    end

    // every accepted push refreshes the retransmit copy
    assign push_fire = push_valid && push_ready;

    // sequencing of one-shot and multi-shot sends
    // requests are only taken in idle; a zero count is sent as one image
    // a multi-shot send ends early when the ring empties or is reinitialised
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= frb_pkg::ST_IDLE;
            remain_q <= 12'h000;
        end else begin
            case (state_q)
                frb_pkg::ST_IDLE: begin
                    if (permit && one_shot_req) begin // RULE2
                        state_q <= frb_pkg::ST_ONE;
                    end else if (permit && multi_shot_req) begin // RULE2
                        state_q <= frb_pkg::ST_MULTI;
                        remain_q <= (multi_count == 12'h000) ? 12'h001 : multi_count; // RULE3
                    end
                end
                frb_pkg::ST_ONE: begin
                    if (push_ready) begin
                        state_q <= frb_pkg::ST_IDLE;
                    end
                end
                frb_pkg::ST_MULTI: begin
                    if (ring_init || held_q == 12'h000) begin
                        state_q <= frb_pkg::ST_IDLE;
                    end else if (ring_pop) begin
                        remain_q <= remain_q - 12'h001;
                        if (remain_q == 12'h001) begin // RULE3
                            state_q <= frb_pkg::ST_IDLE;
                        end
                    end
                end
                default: begin
                    state_q <= frb_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // retransmit copy of everything sent
    // before any send the copy holds its reset value, all zeros
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            last_q <= '0;
        end else if (push_fire) begin
            last_q <= push_data; // RULE7
        end
    end

    // transmit fifo between the sources and the output stage
    frb_fifo #(
        .WIDTH(DATA_W),
        .DEPTH(TX_DEPTH)
    ) u_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .in_valid(push_valid),
        .in_ready(push_ready),
        .in_data(push_data),
        .out_valid(fifo_valid),
        .out_ready(fifo_pop),
        .out_data(fifo_data)
    );

    // registered output stage of the transmit port
    assign fifo_pop = fifo_valid && (!tx_valid_q || tx_ready);

    // the output register holds its word until the host takes it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_valid_q <= 1'b0;
            tx_data_q <= '0;
        end else if (!tx_valid_q || tx_ready) begin
            tx_valid_q <= fifo_valid;
            if (fifo_valid) begin
                tx_data_q <= fifo_data;
            end
        end
    end

    // bus and transmit stream outputs come straight from registers
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign tx_valid = tx_valid_q;
    assign tx_data = tx_data_q;
endmodule

// ==== test/frb_assertions.sv ====
`timescale 1ns/1ps

// ------------------------------------------------------------
// port level checks for frb_top
// ------------------------------------------------------------
module frb_assertions #(
    parameter int DATA_W = 32,
    parameter int RING_DEPTH = 8
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [frb_pkg::ADDR_W-1:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic stream_tx_en,
    input wire logic continuous_shot,
    input wire logic one_shot_req,
    input wire logic multi_shot_req,
    input wire logic cap_valid,
    input wire logic cap_ready,
    input wire logic tx_valid,
    input wire logic tx_ready,
    input wire logic [DATA_W-1:0] tx_data
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // completing read of the control register
    sequence rd_done;
        psel && penable && pready && !pwrite && paddr == frb_pkg::CTRL_OFF;
    endsequence
    // continuous shot on, nothing live, nothing sent for eight cycles
    sequence quiet8;
        (continuous_shot && !stream_tx_en && !cap_valid && !tx_valid)[*8];
    endsequence

    pready_wait_a: assert property (psel && penable && !pready |=> pready)
        else $error("access phase not answered after one wait state");
    unmapped_err_a: assert property (psel && penable && pready && paddr != frb_pkg::CTRL_OFF
        |-> pslverr && prdata == 32'h00000000)
        else $error("unmapped access without error response");
    rsvd_zero_a: assert property (rd_done |-> prdata[7:2] == 6'h00 && !pslverr)
        else $error("reserved bits read nonzero");
    cap_nonzero_a: assert property (rd_done |-> prdata[19:8] != 12'h000)
        else $error("capacity field reads zero");
    cap_clamp_a: assert property (rd_done |-> prdata[19:8] <= RING_DEPTH)
        else $error("capacity above ring depth");
    count_le_cap_a: assert property (rd_done |-> prdata[31:20] <= prdata[19:8])
        else $error("held count above capacity");
    ring_ready_a: assert property (!stream_tx_en |-> cap_ready)
        else $error("capture refused while not streaming");
    tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("transmit word dropped before taken");
    no_send_a: assert property (quiet8 ##0 (one_shot_req || multi_shot_req) |=> !tx_valid [*4])
        else $error("buffered send while continuous shot on");
endmodule

bind frb_top frb_assertions #(.DATA_W(DATA_W), .RING_DEPTH(RING_DEPTH)) u_frb_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .stream_tx_en(stream_tx_en), .continuous_shot(continuous_shot),
    .one_shot_req(one_shot_req), .multi_shot_req(multi_shot_req), .cap_valid(cap_valid),
    .cap_ready(cap_ready), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data));

// ==== test/frb_sink.sv ====
`timescale 1ns/1ps

// ------------------------------------------------------------
// host side consumer of the transmit stream
// ------------------------------------------------------------
module frb_sink #(
    parameter int DATA_W = 32
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic stall,
    input wire logic tx_valid,
    output logic tx_ready,
    input wire logic [DATA_W-1:0] tx_data
);
    logic [DATA_W-1:0] rx_q [$];

    // ready follows the stall request one edge later
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) tx_ready <= 1'b0;
        else tx_ready <= !stall;
    end

    // keep every word taken
    always @(posedge pclk) begin
        if (presetn && tx_valid && tx_ready) rx_q.push_back(tx_data);
    end
endmodule

// ==== test/frb_top_tb.sv ====
`timescale 1ns/1ps

// ------------------------------------------------------------
// bench for frb_top
// ------------------------------------------------------------
module frb_top_tb;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, stream_tx_en = 0;
    logic continuous_shot = 0, one_shot_req = 0, multi_shot_req = 0, format_change = 0;
    logic cap_valid = 0, stall = 0, pready, pslverr, cap_ready, tx_valid, tx_ready, err;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwdata = 32'h0, cap_data = 32'h0, prdata, tx_data, rd;
    logic [11:0] multi_count = 12'h000, format_capacity = 12'h000;
    logic [11:0] fmt_in [3] = '{12'h000, 12'h014, 12'h005};
    logic [11:0] fmt_exp [3] = '{12'h001, 12'h008, 12'h005};
    int errors = 0, total_checks = 0;
    localparam logic [15:0] CO = frb_pkg::CTRL_OFF;

    always #25 pclk = ~pclk;

    frb_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .stream_tx_en(stream_tx_en), .continuous_shot(continuous_shot),
        .one_shot_req(one_shot_req), .multi_shot_req(multi_shot_req),
        .multi_count(multi_count), .format_change(format_change),
        .format_capacity(format_capacity), .cap_valid(cap_valid), .cap_ready(cap_ready),
        .cap_data(cap_data), .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_data(tx_data));
    frb_sink u_sink (.pclk(pclk), .presetn(presetn), .stall(stall), .tx_valid(tx_valid),
        .tx_ready(tx_ready), .tx_data(tx_data));

    task chk(string n, logic [31:0] s, logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            errors++;
            $display("mismatch %s expected %h seen %h", n, e, s);
        end
    endtask
    // one apb transfer, then an idle edge
    task apb(logic w, logic [15:0] a, logic [31:0] d);
        psel <= 1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk); penable <= 1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata; err = pslverr; psel <= 0; penable <= 0;
        @(posedge pclk);
    endtask
    task rd_chk(string n, logic [31:0] e);
        apb(0, CO, 32'h0); chk(n, rd, e);
    endtask
    task cap(logic [31:0] d);
        cap_valid <= 1; cap_data <= d;
        @(posedge pclk);
        while (cap_ready !== 1'b1) @(posedge pclk);
        cap_valid <= 0;
        @(posedge pclk);
    endtask
    task shot(logic one, logic multi);
        one_shot_req <= one; multi_shot_req <= multi;
        @(posedge pclk); one_shot_req <= 0; multi_shot_req <= 0;
    endtask
    // let the stream settle, then compare what the host took
    task rx(int n, logic [31:0] first, logic dat);
        repeat (40) @(posedge pclk);
        chk("rx count", 32'(u_sink.rx_q.size()), 32'(n));
        if (dat) for (int i = 0; i < n; i++) chk("rx data", u_sink.rx_q[i], first + i);
        u_sink.rx_q.delete();
    endtask

    task t_reset;
        rd_chk("reset value", 32'h00000100);
        apb(0, 16'h0638, 32'h0); chk("unmapped err", {31'h0, err}, 32'h1);
        apb(1, CO, 32'h2); shot(1, 0); rx(1, 0, 0);
    endtask
    task t_format;
        for (int i = 0; i < 3; i++) begin
            format_capacity <= fmt_in[i]; format_change <= 1;
            @(posedge pclk); format_change <= 0;
            @(posedge pclk);
            rd_chk("capacity", {12'h000, fmt_exp[i], 8'h02});
        end
    endtask
    task t_ring;
        apb(1, CO, 32'h3);
        for (int i = 0; i < 3; i++) cap(32'ha0 + i);
        rd_chk("held", 32'h00300503);
        apb(1, CO, 32'h3); rd_chk("reinit", 32'h00000503);
        for (int i = 0; i < 7; i++) cap(32'ha0 + i);
        rd_chk("overwrite", 32'h00500503);
        apb(1, CO, 32'hfffffffe); rd_chk("ro fields", 32'h00500502);
    endtask
    task t_multi;
        multi_count <= 12'h003; shot(0, 1); rx(3, 32'ha2, 1);
        rd_chk("after multi", 32'h00200502);
        shot(1, 0); rx(1, 32'ha4, 1);
        continuous_shot <= 1; repeat (8) @(posedge pclk); shot(1, 1); rx(0, 0, 1);
        continuous_shot <= 0; multi_count <= 12'h000; shot(0, 1); rx(1, 32'ha5, 1);
    endtask
    task t_live;
        int n;
        apb(1, CO, 32'h1); stream_tx_en <= 1; stall <= 1;
        @(posedge pclk); n = 0; cap_valid <= 1; cap_data <= 32'hb0;
        @(posedge pclk);
        while (cap_ready === 1'b1 && n < 12) begin
            n++; cap_data <= 32'hb0 + n;
            @(posedge pclk);
        end
        chk("fifo refused", {31'h0, n < 12}, 32'h1);
        stall <= 0;
        @(posedge pclk);
        while (cap_ready !== 1'b1) @(posedge pclk);
        cap_valid <= 0; rx(n + 1, 32'hb0, 1);
        rd_chk("live held", {12'(n + 1 > 5 ? 5 : n + 1), 20'h00501});
        apb(1, CO, 32'h3); rd_chk("path kept", 32'h00000501);
        stream_tx_en <= 0; apb(1, CO, 32'h3); shot(1, 0); rx(1, 32'hb0 + n, 1);
    endtask

    task end_sim;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1;
        @(posedge pclk);
        t_reset; t_format; t_ring; t_multi; t_live;
        end_sim;
    end
    // watchdog
    initial begin
        repeat (5000) @(posedge pclk);
        errors++;
        end_sim;
    end
endmodule
